// ==== src/pgm_filter.sv ====
// symmetric debounce: output follows input after COUNT stable cycles
// assumes the input is already in the system clock domain
module pgm_filter #(
  parameter int COUNT = 2,
  parameter bit INIT  = 1'b0
) (
  input  logic i_sys_clk,
  input  logic i_sys_rst,
  input  logic i_d,
  output logic o_q
);
  localparam int CW = $clog2(COUNT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          q;
  } pgm_filt_state_t;

  pgm_filt_state_t st_ff;
  pgm_filt_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_d == st_ff.q) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == CW'(COUNT - 1)) begin
      nxt_st.q   = i_d;
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '{cnt: '0, q: INIT};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_q = st_ff.q;
endmodule : pgm_filter

// ==== src/pgm_pkg.sv ====
// power-good monitor: shared constants, register layout and carrier types
// assumes a 100 MHz system clock and an AXI4-Lite master with an 8-bit byte address
package pgm_pkg;
  // ==========================================================
  // sizes and timing
  localparam int NUM_RAILS      = 2;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_DEBOUNCE_NS  = 6000;
  localparam int T_PERSIST_NS   = 20000;
  localparam int T_HOLDOFF_NS   = 800000;
  localparam int DEBOUNCE_CYC   = (T_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERSIST_CYC    = (T_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLDOFF_CYC    = (T_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register byte addresses and decode selectors
  localparam logic [7:0] ADDR_CTRL1  = 8'h00;
  localparam logic [7:0] ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_ILIM   = 8'h08;
  localparam logic [7:0] ADDR_INT    = 8'h0c;
  localparam logic [7:0] ADDR_FAULT  = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_STAT   = 8'h18;
  localparam logic [2:0] SEL_CTRL1   = 3'h0;
  localparam logic [2:0] SEL_CTRL2   = 3'h1;
  localparam logic [2:0] SEL_ILIM    = 3'h2;
  localparam logic [2:0] SEL_INT     = 3'h3;
  localparam logic [2:0] SEL_FAULT   = 3'h4;
  localparam logic [2:0] SEL_MASK    = 3'h5;
  localparam logic [2:0] SEL_STAT    = 3'h6;
  localparam logic [2:0] SEL_NONE    = 3'h7;
  // ==========================================================
  // field positions
  localparam int CTRL1_MON_LSB   = 0;
  localparam int CTRL1_WIN_LSB   = 2;
  localparam int CTRL1_POL_BIT   = 4;
  localparam int CTRL1_OD_BIT    = 5;
  localparam int CTRL2_TWSEL_BIT = 0;
  localparam int CTRL2_FHOLD_BIT = 1;
  localparam int CTRL2_MODE_BIT  = 2;
  localparam int CTRL2_TWLVL_BIT = 3;
  localparam int ILIM_STRIDE     = 4;
  localparam int INT_ILIM_LSB    = 0;
  localparam int INT_TW_BIT      = 2;
  localparam int INT_OVP_BIT     = 3;
  localparam int INT_SD_BIT      = 4;
  localparam int STAT_ILIM_LSB   = 0;
  localparam int STAT_TW_BIT     = 2;
  localparam int STAT_PG_BIT     = 3;
  localparam int STAT_OVP_BIT    = 4;
  localparam int STAT_SD_BIT     = 5;
  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] CTRL1_RST   = 8'h13;
  localparam logic [7:0] CTRL2_RST   = 8'h00;
  localparam logic [7:0] ILIM_RST    = 8'h33;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] CTRL1_WMASK = 8'h3f;
  localparam logic [7:0] CTRL2_WMASK = 8'h0b;
  localparam logic [7:0] ILIM_WMASK  = 8'h77;
  localparam logic [7:0] MASK_WMASK  = 8'h07;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef enum logic { PG_GATED, PG_CONTINUOUS } pgm_mode_t;
  typedef enum logic { PH_OTP_LOAD, PH_RUN } pgm_phase_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } pgm_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pgm_axi_rsp_t;
  typedef struct packed {
    logic ramping;
    logic ilim_active;
    logic ov_ok;
    logic uv_ok;
    logic enabled;
  } pgm_rail_in_t;
endpackage : pgm_pkg

// ==== src/pgm_sync.sv ====
// three-stage input synchroniser; output moves once stages two and three agree
// assumes inputs are asynchronous levels from pins or analog comparators
module pgm_sync #(
  parameter int WIDTH = 1
) (
  input  logic             i_sys_clk,
  input  logic             i_sys_rst,
  input  logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } pgm_sync_state_t;

  pgm_sync_state_t st_ff;
  pgm_sync_state_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_async;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // s1 is only read by s2; disagreeing bits keep their last value
    nxt_st.q  = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s2) | ((st_ff.s2 ^ st_ff.s3) & st_ff.q);
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.q;
endmodule : pgm_sync

// ==== src/pgm_top.sv ====
// power-good, fault-latch and warning-interrupt monitor with AXI4-Lite registers
// assumes analog comparators and enable logic deliver asynchronous levels;
// i_sys_rst is the supply undervoltage reset
//
// Behaviour
// R1 - per-rail select bit lets rail voltage validity feed power-good; current limit never
// R2 - a disabled rail is excluded from the power-good combination automatically
// R3 - config bit adds thermal warning status as a power-good source
// R4 - power-good active only if all selected sources valid and no ovp/shutdown flag
// R5 - window bit 0 checks undervoltage only, 1 checks under- and overvoltage
// R6 - config bits choose pin polarity and push-pull or open-drain drive
// R7 - mode bit from one-time config: 0 gated, 1 continuous
// R8 - power-good goes active when the one-time config load finishes
// R9 - gated mode freezes power-good for 800 us after enable or voltage change
// R10 - gated mode latches rail faults; power-good stays low until fault cleared
// R11 - writing 1 clears ovp, shutdown and rail fault flags
// R12 - continuous mode drops power-good on enable, then tracks regulation live
// R13 - continuous mode keeps fault flags latched; ovp/shutdown flags hold output low
// R14 - continuous mode drives power-good low while a rail is ramping
// R15 - continuous mode restores power-good by itself unless fault hold is on
// R16 - fault hold bit keeps power-good low while any fault flag pends
// R17 - three-bit peak current limit setting per rail
// R18 - current limit lasting 20 us sets its flag and pulls the irq line low
// R19 - live current-limit status readable; flag cleared by writing 1
// R20 - current-limit mask bit 1 keeps that event off the irq line
// R21 - config bit picks which thermal warning threshold is used
// R22 - thermal warning sets flag, live status, irq; write 1 clears; maskable
// R23 - power-good status bit reads 1 when valid, whatever the pin polarity
// R24 - power-good sources debounced 6 us on both edges; the thermal warning source goes through the 20 us filter instead
// R25 - irq line low while any unmasked flag is set
//
// Local design decisions: the AXI4-Lite register port and the address map.
module pgm_top
  import pgm_pkg::*;
#(
  parameter int HOLDOFF_CYC_P = HOLDOFF_CYC
) (
  input  logic                          i_sys_clk,
  input  logic                          i_sys_rst,
  input  pgm_axi_req_t                  i_axi,
  output pgm_axi_rsp_t                  o_axi,
  input  pgm_rail_in_t [NUM_RAILS-1:0]  i_rail,
  input  logic                          i_twarn_lo,
  input  logic                          i_twarn_hi,
  input  logic                          i_tsd_det,
  input  logic                          i_ovp_det,
  input  logic                          i_otp_done,
  input  logic                          i_otp_mode,
  output logic [3*NUM_RAILS-1:0]        o_ilim_setting,
  output logic                          o_pg_pin_o,
  output logic                          o_pg_pin_oe,
  output logic                          o_irq_line_n
);
  localparam int HW = $clog2(HOLDOFF_CYC_P + 1);
  localparam int SW = 6 + NUM_RAILS * $bits(pgm_rail_in_t);

  // ==========================================================
  // state
  typedef struct packed {
    pgm_phase_t           phase;
    pgm_mode_t            mode;
    logic [7:0]           ctrl1;
    logic [7:0]           ctrl2;
    logic [7:0]           ilim;
    logic [7:0]           mask;
    logic [NUM_RAILS-1:0] cl_flag;
    logic                 tw_flag;
    logic                 ovp_flag;
    logic                 sd_flag;
    logic [NUM_RAILS-1:0] fault;
    logic [NUM_RAILS-1:0] en_prev;
    logic [NUM_RAILS-1:0] ramp_prev;
    logic [HW-1:0]        hold;
    logic                 pg;
    logic                 pin_o;
    logic                 pin_oe;
    logic                 irq_n;
    logic                 aw_got;
    logic                 w_got;
    logic [7:0]           awaddr;
    logic [7:0]           wdata;
    logic                 wstrb0;
    pgm_axi_rsp_t         rsp;
  } pgm_top_state_t;

  pgm_top_state_t st_ff;
  pgm_top_state_t nxt_st;

  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[7:2] == ADDR_CTRL1[7:2]) begin
      s = SEL_CTRL1;
    end else if (a[7:2] == ADDR_CTRL2[7:2]) begin
      s = SEL_CTRL2;
    end else if (a[7:2] == ADDR_ILIM[7:2]) begin
      s = SEL_ILIM;
    end else if (a[7:2] == ADDR_INT[7:2]) begin
      s = SEL_INT;
    end else if (a[7:2] == ADDR_FAULT[7:2]) begin
      s = SEL_FAULT;
    end else if (a[7:2] == ADDR_MASK[7:2]) begin
      s = SEL_MASK;
    end else if (a[7:2] == ADDR_STAT[7:2]) begin
      s = SEL_STAT;
    end
    return s;
  endfunction : reg_sel

  // ==========================================================
  // input conditioning
  logic [SW-1:0]                sync_out;
  pgm_rail_in_t [NUM_RAILS-1:0] rail_s;
  logic                         otp_mode_s;
  logic                         otp_done_s;
  logic                         ovp_s;
  logic                         tsd_s;
  logic                         twhi_s;
  logic                         twlo_s;
  logic                         tw_raw;
  logic                         tw_f;
  logic                         sd_f;
  logic [NUM_RAILS-1:0]         rail_ok_raw;
  logic [NUM_RAILS-1:0]         rail_ok;
  logic [NUM_RAILS-1:0]         ilim_f;

  pgm_sync #(
    .WIDTH (SW)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_otp_mode, i_otp_done, i_ovp_det, i_tsd_det, i_twarn_hi, i_twarn_lo, i_rail}),
    .o_sync    (sync_out)
  );

  assign {otp_mode_s, otp_done_s, ovp_s, tsd_s, twhi_s, twlo_s, rail_s} = sync_out;
  assign tw_raw = st_ff.ctrl2[CTRL2_TWLVL_BIT] ? twhi_s : twlo_s; // R21

  // warning and shutdown levels each pass their own 20 us filter
  pgm_filter #(
    .COUNT (PERSIST_CYC)
  ) u_tw_filt (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       (tw_raw),
    .o_q       (tw_f)
  );

  pgm_filter #(
    .COUNT (PERSIST_CYC)
  ) u_sd_filt (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       (tsd_s),
    .o_q       (sd_f)
  );

  for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
    // disabled rail reads invalid; masking is done by the monitor term below
    assign rail_ok_raw[g] = rail_s[g].enabled & rail_s[g].uv_ok &
                            (~st_ff.ctrl1[CTRL1_WIN_LSB + g] | rail_s[g].ov_ok); // R5
    pgm_filter #(
      .COUNT (DEBOUNCE_CYC)
    ) u_ok_filt (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_d       (rail_ok_raw[g]),
      .o_q       (rail_ok[g]) // R24
    );
    pgm_filter #(
      .COUNT (PERSIST_CYC)
    ) u_ilim_filt (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_d       (rail_s[g].ilim_active),
      .o_q       (ilim_f[g])
    );
    assign o_ilim_setting[3*g +: 3] = st_ff.ilim[ILIM_STRIDE*g +: 3]; // R17
  end

  // ==========================================================
  // monitor terms
  logic [NUM_RAILS-1:0] monitored;
  logic [NUM_RAILS-1:0] bad;
  logic [NUM_RAILS-1:0] ramp_mon;
  logic [NUM_RAILS-1:0] en_rise;
  logic [NUM_RAILS-1:0] ramp_rise;
  logic [NUM_RAILS-1:0] en_now;
  logic [NUM_RAILS-1:0] ramp_now;
  logic                 src_ok;
  logic [4:0]           pend;

  always_comb begin
    for (int i = 0; i < NUM_RAILS; i++) begin
      en_now[i]   = rail_s[i].enabled;
      ramp_now[i] = rail_s[i].ramping;
    end
  end

  assign monitored = st_ff.ctrl1[CTRL1_MON_LSB +: NUM_RAILS] & en_now; // R1 R2
  assign bad       = monitored & ~rail_ok;
  assign ramp_mon  = monitored & ramp_now;
  assign en_rise   = en_now & ~st_ff.en_prev;
  assign ramp_rise = ramp_now & ~st_ff.ramp_prev;
  assign src_ok    = ~|bad & ~(st_ff.ctrl2[CTRL2_TWSEL_BIT] & tw_f) // R3
                     & ~st_ff.ovp_flag & ~st_ff.sd_flag; // R4 R13
  assign pend      = {st_ff.cl_flag & ~st_ff.mask[INT_ILIM_LSB +: NUM_RAILS], // R20
                      st_ff.tw_flag & ~st_ff.mask[INT_TW_BIT], st_ff.ovp_flag, st_ff.sd_flag};

  // ==========================================================
  // bus handshakes
  logic       aw_fire;
  logic       w_fire;
  logic       ar_fire;
  logic       do_wr;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [7:0] rd_byte;
  logic [7:0] clr_int;
  logic [7:0] clr_fault;
  logic [NUM_RAILS-1:0] fault_set;

  assign aw_fire = i_axi.awvalid & st_ff.rsp.awready;
  assign w_fire  = i_axi.wvalid & st_ff.rsp.wready;
  assign ar_fire = i_axi.arvalid & st_ff.rsp.arready;
  assign do_wr   = st_ff.aw_got & st_ff.w_got & ~st_ff.rsp.bvalid;
  assign wr_sel  = reg_sel(st_ff.awaddr);
  assign rd_sel  = reg_sel(i_axi.araddr);
  assign clr_int   = (do_wr && wr_sel == SEL_INT && st_ff.wstrb0) ? st_ff.wdata : 8'h00;
  assign clr_fault = (do_wr && wr_sel == SEL_FAULT && st_ff.wstrb0) ? st_ff.wdata : 8'h00;

  always_comb begin
    rd_byte = 8'h00;
    if (rd_sel == SEL_CTRL1) begin
      rd_byte = st_ff.ctrl1;
    end else if (rd_sel == SEL_CTRL2) begin
      rd_byte = st_ff.ctrl2;
      rd_byte[CTRL2_MODE_BIT] = (st_ff.mode == PG_CONTINUOUS);
    end else if (rd_sel == SEL_ILIM) begin
      rd_byte = st_ff.ilim;
    end else if (rd_sel == SEL_INT) begin
      rd_byte[INT_ILIM_LSB +: NUM_RAILS] = st_ff.cl_flag;
      rd_byte[INT_TW_BIT]  = st_ff.tw_flag;
      rd_byte[INT_OVP_BIT] = st_ff.ovp_flag;
      rd_byte[INT_SD_BIT]  = st_ff.sd_flag;
    end else if (rd_sel == SEL_FAULT) begin
      rd_byte[NUM_RAILS-1:0] = st_ff.fault;
    end else if (rd_sel == SEL_MASK) begin
      rd_byte = st_ff.mask;
    end else if (rd_sel == SEL_STAT) begin
      rd_byte[STAT_ILIM_LSB +: NUM_RAILS] = ilim_f; // R19
      rd_byte[STAT_TW_BIT]  = tw_f; // R22
      rd_byte[STAT_PG_BIT]  = st_ff.pg; // R23
      rd_byte[STAT_OVP_BIT] = ovp_s;
      rd_byte[STAT_SD_BIT]  = sd_f;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_st    = st_ff;
    fault_set = '0;
    // write channel: address and data accepted in either order
    if (aw_fire) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = i_axi.awaddr;
    end
    if (w_fire) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.wdata  = i_axi.wdata[7:0];
      nxt_st.wstrb0 = i_axi.wstrb[0];
    end
    if (st_ff.rsp.bvalid && i_axi.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_st.aw_got     = 1'b0;
      nxt_st.w_got      = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp  = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (st_ff.wstrb0) begin
        if (wr_sel == SEL_CTRL1) begin
          nxt_st.ctrl1 = st_ff.wdata & CTRL1_WMASK;
        end else if (wr_sel == SEL_CTRL2) begin
          nxt_st.ctrl2 = st_ff.wdata & CTRL2_WMASK;
        end else if (wr_sel == SEL_ILIM) begin
          nxt_st.ilim = st_ff.wdata & ILIM_WMASK;
        end else if (wr_sel == SEL_MASK) begin
          nxt_st.mask = st_ff.wdata & MASK_WMASK;
        end
      end
    end
    nxt_st.rsp.awready = ~nxt_st.aw_got & ~nxt_st.rsp.bvalid;
    nxt_st.rsp.wready  = ~nxt_st.w_got & ~nxt_st.rsp.bvalid;
    // read channel
    if (st_ff.rsp.rvalid && i_axi.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (ar_fire) begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata  = {24'h000000, rd_byte};
      nxt_st.rsp.rresp  = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    nxt_st.rsp.arready = ~nxt_st.rsp.rvalid;

    // power-good sequencing
    nxt_st.en_prev   = en_now;
    nxt_st.ramp_prev = ramp_now;
    case (st_ff.phase)
      PH_OTP_LOAD: begin
        nxt_st.pg = 1'b0;
        if (otp_done_s) begin
          nxt_st.phase = PH_RUN;
          nxt_st.mode  = otp_mode_s ? PG_CONTINUOUS : PG_GATED; // R7
          nxt_st.pg    = 1'b1; // R8
          nxt_st.hold  = HW'(HOLDOFF_CYC_P);
        end
      end
      PH_RUN: begin
        if (st_ff.mode == PG_GATED) begin
          if (|en_rise || |ramp_rise) begin
            nxt_st.hold = HW'(HOLDOFF_CYC_P); // R9
          end else if (st_ff.hold != '0) begin
            nxt_st.hold = st_ff.hold - HW'(1);
          end
          // frozen while the hold-off runs, judged only once it expires
          if (st_ff.hold == '0) begin
            fault_set = bad; // R10
            nxt_st.pg = src_ok & ~|st_ff.fault; // R9 R10
          end
        end else begin
          fault_set = bad & ~ramp_mon; // R13
          nxt_st.pg = src_ok & ~|ramp_mon // R12 R14 R15
                      & ~(st_ff.ctrl2[CTRL2_FHOLD_BIT] & |st_ff.fault); // R16
        end
      end
      default: begin
        nxt_st.phase = PH_OTP_LOAD;
      end
    endcase

    // sticky flags: a set in the clearing cycle wins
    nxt_st.fault    = (st_ff.fault & ~clr_fault[NUM_RAILS-1:0]) | fault_set; // R11 R13
    nxt_st.cl_flag  = (st_ff.cl_flag & ~clr_int[INT_ILIM_LSB +: NUM_RAILS]) | ilim_f; // R18 R19
    nxt_st.tw_flag  = (st_ff.tw_flag & ~clr_int[INT_TW_BIT]) | tw_f; // R22
    nxt_st.ovp_flag = (st_ff.ovp_flag & ~clr_int[INT_OVP_BIT]) | ovp_s; // R11
    nxt_st.sd_flag  = (st_ff.sd_flag & ~clr_int[INT_SD_BIT]) | sd_f; // R11
    nxt_st.irq_n    = ~|pend; // R25

    // pin level and drive type
    if (st_ff.ctrl1[CTRL1_OD_BIT]) begin
      nxt_st.pin_o  = 1'b0;
      nxt_st.pin_oe = ~(st_ff.ctrl1[CTRL1_POL_BIT] ~^ st_ff.pg); // R6
    end else begin
      nxt_st.pin_o  = st_ff.ctrl1[CTRL1_POL_BIT] ~^ st_ff.pg; // R6
      nxt_st.pin_oe = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff             <= '0;
      st_ff.phase       <= PH_OTP_LOAD;
      st_ff.mode        <= PG_GATED;
      st_ff.ctrl1       <= CTRL1_RST;
      st_ff.ctrl2       <= CTRL2_RST;
      st_ff.ilim        <= ILIM_RST;
      st_ff.mask        <= MASK_RST;
      st_ff.pin_oe      <= 1'b1;
      st_ff.irq_n       <= 1'b1;
      st_ff.rsp.awready <= 1'b1;
      st_ff.rsp.wready  <= 1'b1;
      st_ff.rsp.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_axi        = st_ff.rsp;
  assign o_pg_pin_o   = st_ff.pin_o;
  assign o_pg_pin_oe  = st_ff.pin_oe;
  assign o_irq_line_n = st_ff.irq_n;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_irq_line_low: assert property (|pend |=> !o_irq_line_n) // R25
    else $error("irq line not low with pending flag");
  a_ilim_masked: assert property ( // R20
    (st_ff.mask[INT_ILIM_LSB] && st_ff.cl_flag[0] && !st_ff.ovp_flag && !st_ff.sd_flag
     && !(st_ff.tw_flag && !st_ff.mask[INT_TW_BIT])
     && !(st_ff.cl_flag[1] && !st_ff.mask[INT_ILIM_LSB + 1])) |=> o_irq_line_n)
    else $error("masked current limit drove irq");
  a_ilim_sets_flag: assert property (ilim_f[0] |=> st_ff.cl_flag[0] ##1 !o_irq_line_n // R18
                                     or st_ff.mask[INT_ILIM_LSB])
    else $error("current limit flag not set");
  a_twarn_sets: assert property (tw_f |=> st_ff.tw_flag) // R22
    else $error("thermal warning flag not set");
  a_fault_w1c: assert property ((clr_fault[0] && !fault_set[0]) |=> !st_ff.fault[0]) // R11
    else $error("fault flag not cleared by write");
  a_otp_init_pg: assert property ((st_ff.phase == PH_OTP_LOAD && otp_done_s) |=> st_ff.pg) // R8
    else $error("power-good not active after config load");
  a_gated_hold: assert property ( // R9
    (st_ff.phase == PH_RUN && st_ff.mode == PG_GATED && st_ff.hold != '0)
    |=> st_ff.pg == $past(st_ff.pg))
    else $error("power-good moved during hold-off");
  a_pg_sources: assert property ( // R4
    (st_ff.phase == PH_RUN && (!src_ok || |ramp_mon) && st_ff.mode == PG_CONTINUOUS)
    |=> !st_ff.pg)
    else $error("power-good active with invalid source");
  a_fault_holds: assert property ( // R16
    (st_ff.mode == PG_CONTINUOUS && st_ff.ctrl2[CTRL2_FHOLD_BIT] && |st_ff.fault) |=> !st_ff.pg)
    else $error("fault hold did not keep power-good low");
  a_pin_polarity: assert property ( // R6
    !st_ff.ctrl1[CTRL1_OD_BIT] |=> o_pg_pin_oe &&
    o_pg_pin_o == ($past(st_ff.ctrl1[CTRL1_POL_BIT]) ~^ $past(st_ff.pg)))
    else $error("pin level does not match polarity");
endmodule : pgm_top

// ==== test/pgm_host_model.sv ====
// host-side model: resolves the power-good pin and watches the irq line
// assumes a board pull-up on the pin, so a released pin reads high
module pgm_host_model (
  input  wire logic i_pin_o,
  input  wire logic i_pin_oe,
  input  wire logic i_irq_n,
  output logic      o_pin,
  output logic      o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_pin = i_pin_oe ? i_pin_o : 1'b1;
  assign o_irq = ~i_irq_n;
endmodule : pgm_host_model

// ==== test/pgm_top_test.sv ====
// testbench for the power-good monitor: axi4-lite register tasks and directed tests
// assumes a shortened gated hold-off; continuous strap first, gated after a mid-run reset
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module pgm_top_test;
  import pgm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         clk, rst, twl, twh, tsd, ovp, odone, omode, pin_o, pin_oe, irq_n;
  logic                         pin, irq;
  pgm_axi_req_t                 q;
  pgm_axi_rsp_t                 r;
  pgm_rail_in_t [NUM_RAILS-1:0] rail;
  logic [5:0]                   ilim;
  logic [31:0]                  rd_d;
  logic [1:0]                   rd_r;
  int                           n_errors, n_tests;
  pgm_top #(.HOLDOFF_CYC_P(50)) pgm_top_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_axi(q),
    .o_axi(r), .i_rail(rail), .i_twarn_lo(twl), .i_twarn_hi(twh), .i_tsd_det(tsd),
    .i_ovp_det(ovp), .i_otp_done(odone), .i_otp_mode(omode), .o_ilim_setting(ilim),
    .o_pg_pin_o(pin_o), .o_pg_pin_oe(pin_oe), .o_irq_line_n(irq_n));
  pgm_host_model pgm_host_model_i (.i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_irq_n(irq_n),
    .o_pin(pin), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ==========================================================
  // bus tasks: bounded waits, timeout counts as a mismatch
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    q.awvalid <= 1'b1; q.awaddr <= a; q.wvalid <= 1'b1; q.wdata <= d;
    q.wstrb   <= 4'hf; q.bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (r.awready) q.awvalid <= 1'b0;
      if (r.wready) q.wvalid <= 1'b0;
      if (r.bvalid) break;
    end
    q.bready <= 1'b0;
    if (k == 50) begin n_errors++; test_done(); end
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    q.arvalid <= 1'b1; q.araddr <= a; q.rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (r.arready) q.arvalid <= 1'b0;
      if (r.rvalid) break;
    end
    rd_d = r.rdata; rd_r = r.rresp;
    q.rready <= 1'b0;
    if (k == 50) begin n_errors++; test_done(); end
    @(posedge clk);
  endtask : rd
  task automatic pg_is(input logic e);
    rd(ADDR_STAT);
    `CHK(rd_d[STAT_PG_BIT], e)
    `CHK(pin, e)
  endtask : pg_is
  // ==========================================================
  // directed sequence
  initial begin
    n_errors = 0; n_tests = 0; q = '0; rail = '0; rst = 1'b1;
    {twl, twh, tsd, ovp, odone, omode} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL1); `CHK(rd_d[7:0], CTRL1_RST)
    rd(ADDR_ILIM); `CHK(rd_d[7:0], 8'h33)
    `CHK(ilim, 6'h1b)
    rd(8'h1c); `CHK(rd_r, RESP_SLVERR)
    pg_is(1'b0);
    omode <= 1'b1; odone <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ADDR_CTRL2); `CHK(rd_d[CTRL2_MODE_BIT], 1'b1)
    pg_is(1'b1);
    rail[0] <= '{ramping: 1'b0, ilim_active: 1'b0, ov_ok: 1'b1, uv_ok: 1'b1, enabled: 1'b1};
    repeat (10) @(posedge clk);
    pg_is(1'b0);
    repeat (700) @(posedge clk);
    pg_is(1'b1);
    wr(ADDR_FAULT, 32'h1);
    rd(ADDR_FAULT);
    `CHK(rd_d[0], 1'b0)
    rail[0].ov_ok <= 1'b0; // window bit clear: overvoltage ignored
    repeat (700) @(posedge clk);
    pg_is(1'b1);
    wr(ADDR_CTRL1, 32'h17); // window on for rail 0
    repeat (700) @(posedge clk);
    pg_is(1'b0);
    rd(ADDR_FAULT); `CHK(rd_d[0], 1'b1)
    rail[0].ov_ok <= 1'b1;
    repeat (700) @(posedge clk);
    pg_is(1'b1);
    wr(ADDR_CTRL2, 32'h2);
    pg_is(1'b0);
    wr(ADDR_FAULT, 32'h1);
    repeat (5) @(posedge clk);
    pg_is(1'b1);
    rail[1].uv_ok <= 1'b0; // disabled rail must not drop power-good
    rail[0].ramping <= 1'b1;
    repeat (10) @(posedge clk);
    pg_is(1'b0);
    rail[0].ramping <= 1'b0;
    ovp <= 1'b1;
    repeat (10) @(posedge clk);
    ovp <= 1'b0;
    repeat (10) @(posedge clk);
    pg_is(1'b0);
    `CHK(irq, 1'b1)
    wr(ADDR_INT, 32'h8);
    repeat (5) @(posedge clk);
    pg_is(1'b1);
    `CHK(irq, 1'b0)
    twl <= 1'b1;
    repeat (2100) @(posedge clk);
    rd(ADDR_INT); `CHK(rd_d[INT_TW_BIT], 1'b1)
    `CHK(irq, 1'b1)
    wr(ADDR_MASK, 32'h4);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    rail[0].ilim_active <= 1'b1;
    repeat (2100) @(posedge clk);
    rd(ADDR_STAT); `CHK(rd_d[0], 1'b1)
    `CHK(irq, 1'b1)
    pg_is(1'b1);
    wr(ADDR_MASK, 32'h5);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    // second reset: gated strap, hold-off and latched fault
    rst <= 1'b1;
    omode <= 1'b0;
    rail <= '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    pg_is(1'b1);
    rail[0] <= '{ramping: 1'b0, ilim_active: 1'b0, ov_ok: 1'b1, uv_ok: 1'b1, enabled: 1'b1};
    repeat (10) @(posedge clk);
    pg_is(1'b1);
    repeat (100) @(posedge clk);
    pg_is(1'b0);
    repeat (700) @(posedge clk);
    pg_is(1'b0);
    rd(ADDR_FAULT);
    `CHK(rd_d[0], 1'b1)
    wr(ADDR_FAULT, 32'h1);
    repeat (5) @(posedge clk);
    pg_is(1'b1);
    test_done();
  end
endmodule : pgm_top_test
